// *** inc/brf_pkg.sv ***
// Shared constants and types for the block RAM with FIFO control.
// Assumes a single 40 MHz clock domain and synchronous inputs.
package brf_pkg;

  // Memory geometry: 1024 words of 9 bits.
  localparam int unsigned BRF_ADDR_W = 10;
  localparam int unsigned BRF_DATA_W = 9;
  localparam int unsigned BRF_DEPTH  = 1024;

  // Buffer in the read data path holds two words.
  localparam int unsigned BRF_BUF_DEPTH = 2;

  // Reset values of pointers, level and outputs.
  localparam logic [BRF_ADDR_W-1:0] BRF_PTR_RST   = 10'h000;
  localparam logic [BRF_ADDR_W-1:0] BRF_LEVEL_RST = 10'h000;
  localparam logic [BRF_DATA_W-1:0] BRF_DOUT_RST  = 9'h000;

  // The empty flag compares against this fixed level.
  localparam logic [BRF_ADDR_W-1:0] BRF_EMPTY_LEVEL = 10'h000;

  // One step of a pointer or the fill level.
  localparam logic [BRF_ADDR_W-1:0] BRF_STEP = 10'h001;

  // Write behaviour of a RAM port.
  typedef enum logic [1:0] {
    BRF_WM_NORMAL,
    BRF_WM_THROUGH,
    BRF_WM_OLD_DATA
  } brf_wmode_e;

endpackage : brf_pkg

// *** hw/brf_skid_buffer.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes the brf_pkg package and one clock with a synchronous reset.
module brf_skid_buffer
  import brf_pkg::*;
(
  // Clock and reset.
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          flush,
  // Filling side.
  input  wire logic                          inValid,
  output logic                               inReady,
  input  wire logic [brf_pkg::BRF_DATA_W-1:0] inData,
  // Draining side.
  output logic                               outValid,
  input  wire logic                          outReady,
  output logic [brf_pkg::BRF_DATA_W-1:0]      outData
);

  //////////////////////////////////////////////////////////////////////////
  // State.

  // Entry 0 is the head; entry 1 is behind it.
  typedef struct packed {
    logic [1:0][BRF_DATA_W-1:0] entry;
    logic [1:0]                 count;
  } brf_buf_s;

  brf_buf_s state_q; // Registered state.
  brf_buf_s state_d; // Next state.

  logic push; // A word enters this cycle.
  logic pop;  // A word leaves this cycle.

  // Ready is honest: it drops only when both entries are taken.
  assign inReady  = (state_q.count != 2'(BRF_BUF_DEPTH));
  assign outValid = (state_q.count != 2'h0);
  assign outData  = state_q.entry[0];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  // A pop shifts entry 1 forward; a push lands behind what remains.
  always_comb begin
    state_d = state_q;
    if (pop) begin
      state_d.entry[0] = state_q.entry[1];
    end
    if (push) begin
      if (state_q.count == 2'h0 || (state_q.count == 2'h1 && pop)) begin
        state_d.entry[0] = inData;
      end else begin
        state_d.entry[1] = inData;
      end
    end
    state_d.count = state_q.count + 2'(push) - 2'(pop);
    // A flush drops everything held, whatever else happens.
    if (flush) begin
      state_d.count = 2'h0;
    end
  end

  // Register the whole state.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule : brf_skid_buffer

// *** hw/brf_block_ram_fifo.sv ***
// Embedded RAM block with per-port write behaviour and a FIFO mode.
// Assumes one clock and inputs synchronous to it; user logic sits on
// both ports. Clock enables stand in for the two port clocks.
module brf_block_ram_fifo
  import brf_pkg::*;
(
  // Clock and resets.
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           chip_wide_reset_n,
  input  wire logic                           fifoClearOrPortAClear,
  input  wire logic                           rewindOrPortBClear,
  // Mode: high selects FIFO mode, low dual-port RAM mode.
  input  wire logic                           fifoMode,
  // RAM port A.
  input  wire logic                           portAEnable,
  input  wire logic                           portAWrite,
  input  wire logic [brf_pkg::BRF_ADDR_W-1:0] portAAddr,
  input  wire logic [brf_pkg::BRF_DATA_W-1:0] portAWdata,
  input  brf_pkg::brf_wmode_e                 portAMode,
  output logic      [brf_pkg::BRF_DATA_W-1:0] portARdata,
  // RAM port B.
  input  wire logic                           portBEnable,
  input  wire logic                           portBWrite,
  input  wire logic [brf_pkg::BRF_ADDR_W-1:0] portBAddr,
  input  wire logic [brf_pkg::BRF_DATA_W-1:0] portBWdata,
  input  brf_pkg::brf_wmode_e                 portBMode,
  output logic      [brf_pkg::BRF_DATA_W-1:0] portBRdata,
  // FIFO write port.
  input  wire logic                           writeClockEnable,
  input  wire logic                           writeStrobe,
  input  wire logic [brf_pkg::BRF_DATA_W-1:0] writeData,
  // FIFO read port.
  input  wire logic                           fetchClockEnable,
  input  wire logic                           fetchStrobe,
  output logic                                fetchValid,
  output logic      [brf_pkg::BRF_DATA_W-1:0] fetchData,
  // Flag thresholds.
  input  wire logic [brf_pkg::BRF_ADDR_W-1:0] fullThresh,
  input  wire logic [brf_pkg::BRF_ADDR_W-1:0] nearlyFullThresh,
  input  wire logic [brf_pkg::BRF_ADDR_W-1:0] nearlyEmptyThresh,
  // FIFO flags and level.
  output logic                                fullFlag,
  output logic                                nearlyFullFlag,
  output logic                                nearlyEmptyFlag,
  output logic                                emptyFlag,
  output logic      [brf_pkg::BRF_ADDR_W-1:0] fillLevel
);

  //////////////////////////////////////////////////////////////////////////
  // State and storage.

  // All control state of the block in one record.
  // The level counts only words still in the array; up to two more may
  // wait in the read buffer, so the FIFO holds the full threshold plus
  // two words before the writer is refused.
  typedef struct packed {
    logic [BRF_ADDR_W-1:0] wrPtr;       // Next FIFO write location.
    logic [BRF_ADDR_W-1:0] rdPtr;       // Next FIFO read location.
    logic [BRF_ADDR_W-1:0] level;       // Words still in the array, not yet moved to the buffer.
    logic                  full;        // Level at full threshold.
    logic                  nearlyFull;  // Level at near-full threshold.
    logic                  nearlyEmpty; // Level at near-empty threshold.
    logic                  empty;       // Level at zero.
    logic [BRF_DATA_W-1:0] portAOut;    // Port A output holder.
    logic [BRF_DATA_W-1:0] portBOut;    // Port B output holder.
  } brf_state_s;

  brf_state_s state_q; // Registered state.
  brf_state_s state_d; // Next state.

  // The array is kept apart from the record: it is storage, not control.
  logic [BRF_DATA_W-1:0] memArray [BRF_DEPTH];

  logic                  fifoWrite;   // Accepted FIFO write.
  logic                  fifoRead;    // Word moved from array to buffer.
  logic                  bufInReady;  // Buffer has room.
  logic                  bufFlush;    // Buffer contents discarded.
  logic                  fetchPop;    // Reader takes the head word.
  logic                  clearPortA;  // Port A output clear.
  logic                  clearPortB;  // Port B output clear.
  logic                  fifoClear;   // Whole FIFO clear.
  logic                  fifoRewind;  // Read pointer rewind.
  logic                  ramWriteA;   // Array write from port A.
  logic                  ramWriteB;   // Array write from port B.
  logic [BRF_DATA_W-1:0] memReadA;    // Word at port A address.
  logic [BRF_DATA_W-1:0] memReadB;    // Word at port B address.
  logic [BRF_DATA_W-1:0] memFifoHead; // Word at read pointer.

  //////////////////////////////////////////////////////////////////////////
  // Request decode.

  // Each local reset input does one of two jobs, picked by the mode. In
  // RAM mode they clear the port outputs; in FIFO mode they clear the
  // whole FIFO or rewind its read side. The chip-wide reset always clears
  // both port outputs, whatever the mode.
  // The two local resets change meaning with the mode.
  assign fifoClear  = fifoMode && fifoClearOrPortAClear;
  assign fifoRewind = fifoMode && rewindOrPortBClear;
  assign clearPortA = !chip_wide_reset_n ||
                      (!fifoMode && fifoClearOrPortAClear);
  assign clearPortB = !chip_wide_reset_n ||
                      (!fifoMode && rewindOrPortBClear);

  // The writer's enable pair gates every FIFO write; full blocks it.
  assign fifoWrite = fifoMode && writeClockEnable && writeStrobe &&
                     !state_q.full && !fifoClear;

  // The move is the only consumer of the array in FIFO mode, so the read
  // pointer and the level step exactly once per moved word.
  // Words move to the buffer while stored and the buffer has room.
  // Both clear and rewind suppress the move so no stale word slips in.
  assign fifoRead = fifoMode && !state_q.empty && bufInReady &&
                    !fifoClear && !fifoRewind;

  // The reader pops only with both its enables high.
  assign fetchPop = fetchClockEnable && fetchStrobe;
  assign bufFlush = fifoClear || fifoRewind || !fifoMode;

  // In RAM mode each port writes the array on its own enables.
  assign ramWriteA = !fifoMode && portAEnable && portAWrite;
  assign ramWriteB = !fifoMode && portBEnable && portBWrite;

  // Reading without a clock keeps old-data mode simple: the array holds
  // its old word until the edge that writes it. A real block RAM would
  // need a registered read and one more cycle of latency here.
  // Asynchronous array reads feed the output holders and the buffer.
  assign memReadA    = memArray[portAAddr];
  assign memReadB    = memArray[portBAddr];
  assign memFifoHead = memArray[state_q.rdPtr];

  //////////////////////////////////////////////////////////////////////////
  // Output holder update for one RAM port.

  // Picks the next output word from the port mode and access kind.
  function automatic logic [BRF_DATA_W-1:0] nextPortOut(
    input logic                  enable,
    input logic                  write,
    input brf_wmode_e            mode,
    input logic [BRF_DATA_W-1:0] held,
    input logic [BRF_DATA_W-1:0] wdata,
    input logic [BRF_DATA_W-1:0] stored
  );
    logic [BRF_DATA_W-1:0] result;
    result = held;
    if (enable && !write) begin
      // A read always shows the addressed word.
      result = stored;
    end else if (enable && write) begin
      case (mode)
        BRF_WM_NORMAL: begin
          result = held;
        end
        BRF_WM_THROUGH: begin
          result = wdata;
        end
        BRF_WM_OLD_DATA: begin
          // The array still holds the old word during this cycle.
          result = stored;
        end
        default: begin
          result = held;
        end
      endcase
    end
    return result;
  endfunction : nextPortOut

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  // Pointers, level and flags form the dedicated FIFO control; the
  // user never computes them.
  always_comb begin
    state_d = state_q;
    if (fifoWrite) begin
      state_d.wrPtr = state_q.wrPtr + BRF_STEP;
    end
    if (fifoRead) begin
      state_d.rdPtr = state_q.rdPtr + BRF_STEP;
    end
    state_d.level = state_q.level + (fifoWrite ? BRF_STEP : '0)
                    - (fifoRead ? BRF_STEP : '0);
    if (fifoRewind) begin
      // Start again from the first word written since the last clear.
      // Only the read side moves; stored data stays.
      state_d.rdPtr = BRF_PTR_RST;
      state_d.level = state_q.wrPtr + (fifoWrite ? BRF_STEP : '0);
    end
    if (fifoClear) begin
      state_d.wrPtr = BRF_PTR_RST;
      state_d.rdPtr = BRF_PTR_RST;
      state_d.level = BRF_LEVEL_RST;
    end

    // A full threshold of zero makes the full flag rise on the first edge after
    // reset; thresholds outside their legal ranges are not trapped here.
    // Flags follow the next level so they settle with it.
    state_d.full        = (state_d.level >= fullThresh);
    state_d.nearlyFull  = (state_d.level >= nearlyFullThresh);
    state_d.nearlyEmpty = (state_d.level <= nearlyEmptyThresh);
    state_d.empty       = (state_d.level == BRF_EMPTY_LEVEL);

    // Output holders of the two RAM ports.
    state_d.portAOut = nextPortOut(portAEnable && !fifoMode, portAWrite,
                                   portAMode, state_q.portAOut,
                                   portAWdata, memReadA);
    state_d.portBOut = nextPortOut(portBEnable && !fifoMode, portBWrite,
                                   portBMode, state_q.portBOut,
                                   portBWdata, memReadB);
    if (clearPortA) begin
      state_d.portAOut = BRF_DOUT_RST;
    end
    if (clearPortB) begin
      state_d.portBOut = BRF_DOUT_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  // The port output holders are cleared on the next edge, not at once:
  // with one clock an asynchronous clear would buy nothing but a second
  // reset path to time.
  // Flags are registered here; with one clock the write side and the
  // read side share this edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q             <= '0;
      state_q.empty       <= 1'b1;
      state_q.nearlyEmpty <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // The array has no reset; its contents after power-up are unknown and
  // a user must write a word before reading it back.
  // Array writes; the FIFO writes through the write pointer.
  // If both RAM ports hit one address, port B wins.
  always_ff @(posedge ref_clk) begin
    if (fifoWrite) begin
      memArray[state_q.wrPtr] <= writeData;
    end
    if (ramWriteA) begin
      memArray[portAAddr] <= portAWdata;
    end
    if (ramWriteB) begin
      memArray[portBAddr] <= portBWdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data buffer.

  // The buffer lets the reader stall without losing a fetched word.
  // It is flushed on clear, on rewind and outside FIFO mode, so a word
  // fetched before any of these reaches the reader only if it is popped in that same cycle.
  brf_skid_buffer u_fetchBuf (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .flush    (bufFlush),
    .inValid  (fifoRead),
    .inReady  (bufInReady),
    .inData   (memFifoHead),
    .outValid (fetchValid),
    .outReady (fetchPop),
    .outData  (fetchData)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Every data and flag output comes from a register, so the user logic
  // sees no combinational path from its own inputs.
  assign portARdata      = state_q.portAOut;
  assign portBRdata      = state_q.portBOut;
  assign fullFlag        = state_q.full;
  assign nearlyFullFlag  = state_q.nearlyFull;
  assign nearlyEmptyFlag = state_q.nearlyEmpty;
  assign emptyFlag       = state_q.empty;
  assign fillLevel       = state_q.level;

endmodule : brf_block_ram_fifo

// *** verification/brf_checker.sv ***
// Concurrent checks on the ports of the RAM/FIFO block.
// Assumes brf_pkg and thresholds held steady while traffic runs.
module brf_checker
  import brf_pkg::*;
(
  // Clock and resets.
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic                   chip_wide_reset_n,
  input wire logic                   fifoClearOrPortAClear,
  input wire logic                   rewindOrPortBClear,
  // Mode and requests.
  input wire logic                   fifoMode,
  input wire logic                   portAEnable,
  input wire logic                   portAWrite,
  input brf_pkg::brf_wmode_e         portAMode,
  input wire logic                   writeClockEnable,
  input wire logic                   writeStrobe,
  input wire logic [BRF_ADDR_W-1:0]  fullThresh,
  input wire logic [BRF_ADDR_W-1:0]  nearlyEmptyThresh,
  // Outputs watched.
  input wire logic [BRF_DATA_W-1:0]  portARdata,
  input wire logic [BRF_DATA_W-1:0]  portBRdata,
  input wire logic                   fetchValid,
  input wire logic                   fullFlag,
  input wire logic                   nearlyEmptyFlag,
  input wire logic                   emptyFlag,
  input wire logic [BRF_ADDR_W-1:0]  fillLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wasRst_q;  // Flags settle one edge after reset, so skip that edge.
  always_ff @(posedge ref_clk) wasRst_q <= sys_rst;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || wasRst_q);
  ////////////////////////////////////////////////////////////////////////
  chk_full_level: assert property (
    fullFlag == (fillLevel >= fullThresh))
    else $error("full flag disagrees with fill level");
  chk_near_empty: assert property (
    nearlyEmptyFlag == (fillLevel <= nearlyEmptyThresh))
    else $error("nearly empty flag disagrees with fill level");
  chk_empty_level: assert property (
    emptyFlag == (fillLevel == 10'h000))
    else $error("empty flag disagrees with fill level");
  chk_full_refuse: assert property (fifoMode && fullFlag && writeStrobe
    && writeClockEnable && !fifoClearOrPortAClear && !rewindOrPortBClear
    |=> fillLevel <= $past(fillLevel))
    else $error("write taken while full");
  chk_fifo_clear: assert property (fifoMode && fifoClearOrPortAClear
    |=> fillLevel == 10'h000 && emptyFlag && !fetchValid)
    else $error("clear left data in the fifo");
  chk_port_a_clr: assert property (!fifoMode && fifoClearOrPortAClear
    |=> portARdata == 9'h000)
    else $error("port A output not cleared");
  chk_chip_clear: assert property (!chip_wide_reset_n
    |=> portARdata == 9'h000 && portBRdata == 9'h000)
    else $error("chip reset left a port output set");
  chk_normal_hold: assert property (!fifoMode && portAEnable && portAWrite
    && portAMode == BRF_WM_NORMAL && !fifoClearOrPortAClear
    && chip_wide_reset_n |=> $stable(portARdata))
    else $error("normal write changed port A output");
endmodule : brf_checker

bind brf_block_ram_fifo brf_checker u_chk (.ref_clk, .sys_rst,
  .chip_wide_reset_n, .fifoClearOrPortAClear, .rewindOrPortBClear,
  .fifoMode, .portAEnable, .portAWrite, .portAMode, .writeClockEnable,
  .writeStrobe, .fullThresh, .nearlyEmptyThresh, .portARdata,
  .portBRdata, .fetchValid, .fullFlag, .nearlyEmptyFlag, .emptyFlag,
  .fillLevel);

// *** verification/brf_fetch_user.sv ***
// Reader-side user logic: pops FIFO words into a queue.
// Assumes one clock; the bench holds it back through stall.
module brf_fetch_user
  import brf_pkg::*;
(
  // Clock and bench control.
  input wire logic                           ref_clk,
  input wire logic                           stall,
  // FIFO read port.
  output logic                               fetchClockEnable,
  output logic                               fetchStrobe,
  input wire logic                           fetchValid,
  input wire logic [brf_pkg::BRF_DATA_W-1:0] fetchData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [BRF_DATA_W-1:0] seen[$];  // Popped words, oldest first.
  initial begin
    fetchClockEnable = 1'b0;
    fetchStrobe = 1'b0;
  end
  // A word is taken at the edge where enable, strobe and valid meet. The
  // requests move 1 ns after an edge, from the stall seen at that edge,
  // so the bench changing stall between edges never races this model.
  always @(posedge ref_clk) begin
    if (fetchClockEnable && fetchStrobe && fetchValid) begin
      seen.push_back(fetchData);
    end
    fetchClockEnable <= #1 !stall;
    fetchStrobe      <= #1 !stall;
  end
endmodule : brf_fetch_user

// *** verification/testbench.sv ***
// Bench for the RAM/FIFO block: port write modes, clears, fill, refusal,
// drain, rewind. Assumes brf_pkg, the reader model and the checker bind.
module testbench;
  import brf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, sys_rst = 1'b1, chip_wide_reset_n = 1'b1;
  logic fifoClearOrPortAClear = 1'b0, rewindOrPortBClear = 1'b0;
  logic fifoMode = 1'b0, stall = 1'b1;
  logic portAEnable = 1'b0, portAWrite = 1'b0;
  logic portBEnable = 1'b0, portBWrite = 1'b0;
  logic [9:0] portAAddr = 10'h000, portBAddr = 10'h000;
  logic [8:0] portAWdata = 9'h000, portBWdata = 9'h000;
  brf_wmode_e portAMode = BRF_WM_NORMAL, portBMode = BRF_WM_NORMAL;
  logic writeClockEnable = 1'b0, writeStrobe = 1'b0;
  logic [8:0] writeData = 9'h000, portARdata, portBRdata, fetchData;
  logic fetchClockEnable, fetchStrobe, fetchValid, fullFlag;
  logic nearlyFullFlag, nearlyEmptyFlag, emptyFlag;
  logic [9:0] fillLevel;
  logic [9:0] fullThresh = 10'h006, nearlyFullThresh = 10'h004;
  logic [9:0] nearlyEmptyThresh = 10'h002;
  logic [8:0] expQ[$];  // Words the FIFO accepted, in order.
  int failures = 0, samplesChecked = 0;
  brf_block_ram_fifo u_dut (
    .ref_clk, .sys_rst, .chip_wide_reset_n, .fifoClearOrPortAClear,
    .rewindOrPortBClear, .fifoMode, .portAEnable, .portAWrite, .portAAddr,
    .portAWdata, .portAMode, .portARdata, .portBEnable, .portBWrite,
    .portBAddr, .portBWdata, .portBMode, .portBRdata, .writeClockEnable,
    .writeStrobe, .writeData, .fetchClockEnable, .fetchStrobe, .fetchValid,
    .fetchData, .fullThresh, .nearlyFullThresh, .nearlyEmptyThresh,
    .fullFlag, .nearlyFullFlag, .nearlyEmptyFlag, .emptyFlag, .fillLevel);
  brf_fetch_user u_reader (.ref_clk, .stall, .fetchClockEnable,
    .fetchStrobe, .fetchValid, .fetchData);
  always #12.5 ref_clk = ~ref_clk;  // 40 MHz.
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (failures == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic check(string name, logic [9:0] exp, logic [9:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // All tasks start and end 1 ns after a rising edge.
  task automatic ram(bit p, bit w, logic [9:0] a, logic [8:0] d,
                     brf_wmode_e m, logic [8:0] exp);
    // Only this port's enable is up; the caller releases it after the last
    // access, so no call lowers and raises an enable in one time step.
    {portAEnable, portBEnable} = p ? 2'b01 : 2'b10;
    if (p) begin
      {portBWrite, portBAddr, portBWdata} = {w, a, d};
      portBMode = m;
    end else begin
      {portAWrite, portAAddr, portAWdata} = {w, a, d};
      portAMode = m;
    end
    @(posedge ref_clk);
    #1;
    check(p ? "portBRdata" : "portARdata", {1'b0, exp},
          {1'b0, p ? portBRdata : portARdata});
  endtask : ram
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
  endtask : pulse
  // Strobe stays up between pushes so writes run back to back.
  task automatic push(logic [8:0] d);
    {writeClockEnable, writeStrobe, writeData} = {2'b11, d};
    if (fullFlag === 1'b0) expQ.push_back(d);
    @(posedge ref_clk);
    #1;
  endtask : push
  task automatic drain_cmp();
    int n;
    n = 0;
    while (!(emptyFlag === 1'b1 && fetchValid === 1'b0) && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 200) begin
      failures++;
      $display("[ERR] drain expected empty in 200 cycles seen busy");
    end
    check("seen count", 10'(expQ.size()), 10'(u_reader.seen.size()));
    foreach (expQ[i]) begin
      if (i < u_reader.seen.size()) begin
        check("fetchData", {1'b0, expQ[i]}, {1'b0, u_reader.seen[i]});
      end
    end
  endtask : drain_cmp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      ram(p[0], 1'b1, 10'h005, 9'h155, BRF_WM_NORMAL, 9'h000);
      ram(p[0], 1'b0, 10'h005, 9'h000, BRF_WM_NORMAL, 9'h155);
      ram(p[0], 1'b1, 10'h005, 9'h0AA, BRF_WM_THROUGH, 9'h0AA);
      ram(p[0], 1'b1, 10'h005, 9'h133, BRF_WM_OLD_DATA, 9'h0AA);
    end
    {portAEnable, portBEnable} = 2'b00;
    pulse(fifoClearOrPortAClear);
    check("portARdata", 10'h000, {1'b0, portARdata});
    // Port B last showed the old word of its old-data write.
    check("portBRdata", 10'h0AA, {1'b0, portBRdata});
    pulse(rewindOrPortBClear);
    check("portBRdata", 10'h000, {1'b0, portBRdata});
    ram(1'b0, 1'b0, 10'h005, 9'h000, BRF_WM_NORMAL, 9'h133);
    ram(1'b1, 1'b0, 10'h005, 9'h000, BRF_WM_NORMAL, 9'h133);
    {portAEnable, portBEnable} = 2'b00;
    chip_wide_reset_n = 1'b0;
    @(posedge ref_clk);
    #1 chip_wide_reset_n = 1'b1;
    check("portARdata", 10'h000, {1'b0, portARdata});
    check("portBRdata", 10'h000, {1'b0, portBRdata});
    // Fill with the reader stalled until writes are refused.
    fifoMode = 1'b1;
    for (int i = 0; i < 12; i++) push(9'h100 + i[8:0]);
    writeStrobe = 1'b0;
    check("fillLevel", 10'h006, fillLevel);
    check("flags", 10'h00C, {6'h00, fullFlag, nearlyFullFlag,
                             nearlyEmptyFlag, emptyFlag});
    stall = 1'b0;
    drain_cmp();
    check("nearlyEmptyFlag", 10'h001, {9'h000, nearlyEmptyFlag});
    u_reader.seen.delete();
    // Every word since the clear is still stored, so the rewind replays
    // all of them in order.
    pulse(rewindOrPortBClear);
    check("fillLevel", 10'(expQ.size()), fillLevel);
    drain_cmp();
    stall = 1'b1;
    for (int i = 0; i < 3; i++) push(9'h0C0 + i[8:0]);
    writeStrobe = 1'b0;
    pulse(fifoClearOrPortAClear);
    check("fillLevel", 10'h000, fillLevel);
    check("emptyFlag", 10'h001, {9'h000, emptyFlag});
    check("fetchValid", 10'h000, {9'h000, fetchValid});
    expQ.delete();
    u_reader.seen.delete();
    push(9'h1C3);
    writeStrobe = 1'b0;
    stall = 1'b0;
    drain_cmp();
    print_verdict();
  end
endmodule : testbench
